// >>> rtl/spi_defs.svh
// Register offsets, field positions, reset values and counts of the SPI master
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH

// ****************************************************************
// Register offsets on the special function register port
// ****************************************************************
`define CLKDIV_ADDR 8'hD2
`define IRQEN_ADDR 8'hD7
`define TXDATA_ADDR 8'hD3
`define RXDATA_ADDR 8'hD4
`define STATUS_ADDR 8'hD5

// ****************************************************************
// Reset values
// ****************************************************************
`define CLKDIV_RST 8'h04
`define IRQEN_RST 8'h00

// ****************************************************************
// Field positions: bits 0-3 shared by enable and status, busy in status, divider selects in the divider register
// ****************************************************************
`define BIT_TX_END 3
`define BIT_RX_OVERRUN 2
`define BIT_TX_EMPTY 1
`define BIT_RX_FULL 0
`define BIT_BUSY 4
`define BIT_DIVIDE_BY_128_SEL 7
`define BIT_DIVIDE_BY_64_SEL 6
`define BIT_DIVIDE_BY_32_SEL 5
`define BIT_DIVIDE_BY_16_SEL 4
`define BIT_DIVIDE_BY_8_SEL 3
`define BIT_DIVIDE_BY_4_SEL 2

// ****************************************************************
// Serial clock half periods, in system clocks
// ****************************************************************
`define HALF_DIVIDE_BY_128_SEL 8'h40
`define HALF_DIVIDE_BY_64_SEL 8'h20
`define HALF_DIVIDE_BY_32_SEL 8'h10
`define HALF_DIVIDE_BY_16_SEL 8'h08
`define HALF_DIVIDE_BY_8_SEL 8'h04
`define HALF_DIVIDE_BY_4_SEL 8'h02

// ****************************************************************
// Word size and FIFO depth
// ****************************************************************
`define WORD_BITS 8
`define TX_FIFO_DEPTH 16

`endif

// >>> rtl/spi_pkg.sv
// Types shared by the SPI master design files
package spi_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [7:0] half_cnt_t;
    // Shift engine states, one-hot
    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_LOW = 3'b010,
        SH_HIGH = 3'b100
    } shift_state_t;
endpackage

// >>> rtl/fifo_if.sv
// Valid/ready stream carrier between the SPI master and its FIFO
`timescale 1ns/10ps
interface fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface // fifo_if

// >>> rtl/sync_fifo.sv
// Synchronous FIFO with registered read data and valid/ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, active high
    fifo_if.snk inPort, // Filling side
    fifo_if.src outPort // Draining side
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic [WIDTH-1:0] outData_reg;
    logic outValid_reg;
    logic push;
    logic pop;

    // Honest full: ready drops only when every slot is taken
    assign inPort.ready = (count_reg != (AW+1)'(DEPTH));
    assign push = inPort.valid && inPort.ready;
    // Refill the output register whenever it is empty or being taken
    assign pop = (!outValid_reg || outPort.ready) && (count_reg != '0);
    assign outPort.data = outData_reg;
    assign outPort.valid = outValid_reg;

    // Storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_reg] <= inPort.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Registered read port
    always_ff @(posedge mclk) begin
        if (rst) begin
            outValid_reg <= 1'b0;
            outData_reg <= '0;
        end else if (pop) begin
            outValid_reg <= 1'b1;
            outData_reg <= mem[rdPtr_reg];
        end else if (outPort.ready) begin
            outValid_reg <= 1'b0;
        end
    end

    a_no_overfill: assert property (@(posedge mclk) disable iff (rst)
        count_reg <= (AW+1)'(DEPTH))
        else $error("fifo fill count beyond depth");
endmodule // sync_fifo

// >>> rtl/spi_master_controller.sv
// SPI master controller: register port, transmit FIFO, shift engine
`timescale 1ns/10ps
`include "spi_defs.svh"
module spi_master_controller
    import spi_pkg::*;
#(
    parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
    input wire logic mclk, // System clock, 250 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] sfrAddr, // Register address
    input wire logic sfrWr, // Register write strobe
    input wire logic sfrRd, // Register read strobe
    input wire logic [7:0] sfrWrData, // Register write data
    output logic [7:0] sfrRdData, // Register read data
    output logic txSpace, // Transmit FIFO can take a word
    input wire logic serialInLine, // Data from slave
    output logic serialOutLine, // Data to slave
    output logic serialClockOut, // Serial clock to slave
    output logic slaveSelectOut_n, // Slave select, active low
    output logic irq // Interrupt request, active high
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    byte_t clkDiv_reg;
    byte_t irqEn_reg;
    byte_t rxHold_reg;
    byte_t shift_reg;
    byte_t rdData_reg;
    shift_state_t state_reg;
    half_cnt_t halfCnt;
    half_cnt_t divCnt_reg;
    logic [2:0] bitCnt_reg;
    logic inBit_reg;
    logic sclk_reg;
    logic ssel_reg;
    logic rxFull_reg;
    logic rxOverrun_reg;
    logic txEnd_reg;
    logic irq_reg;
    logic tick;
    logic lastEdge;
    logic rxDone;
    logic txEmpty;
    logic [3:0] status;
    logic wrTx;
    fifo_if #(.WIDTH(`WORD_BITS)) pushIf ();
    fifo_if #(.WIDTH(`WORD_BITS)) popIf ();

    // ****************************************************************
    // Transmit FIFO
    // ****************************************************************
    // Writes to a full FIFO are dropped; software watches txSpace
    assign wrTx = sfrWr && (sfrAddr == `TXDATA_ADDR);
    assign pushIf.data = sfrWrData;
    assign pushIf.valid = wrTx;
    assign txSpace = pushIf.ready;

    sync_fifo #(
        .WIDTH(`WORD_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW($clog2(FIFO_DEPTH))
    ) txFifo (
        .mclk(mclk),
        .rst(rst),
        .inPort(pushIf),
        .outPort(popIf)
    );

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Reset values
    always_ff @(posedge mclk) begin
        if (rst) begin
            clkDiv_reg <= `CLKDIV_RST;
            irqEn_reg <= `IRQEN_RST;
        end else if (sfrWr) begin
            if (sfrAddr == `CLKDIV_ADDR) begin
                clkDiv_reg <= {sfrWrData[7:2], 2'b00}; // Low bits unused
            end else if (sfrAddr == `IRQEN_ADDR) begin
                irqEn_reg <= {4'h0, sfrWrData[3:0]}; // Upper bits reserved
            end
        end
    end

    // ****************************************************************
    // Clock divider
    // ****************************************************************
    // Half period from divider; highest bit wins if several
    always_comb begin
        if (clkDiv_reg[`BIT_DIVIDE_BY_128_SEL]) begin
            halfCnt = `HALF_DIVIDE_BY_128_SEL;
        end else if (clkDiv_reg[`BIT_DIVIDE_BY_64_SEL]) begin
            halfCnt = `HALF_DIVIDE_BY_64_SEL;
        end else if (clkDiv_reg[`BIT_DIVIDE_BY_32_SEL]) begin
            halfCnt = `HALF_DIVIDE_BY_32_SEL;
        end else if (clkDiv_reg[`BIT_DIVIDE_BY_16_SEL]) begin
            halfCnt = `HALF_DIVIDE_BY_16_SEL;
        end else if (clkDiv_reg[`BIT_DIVIDE_BY_8_SEL]) begin
            halfCnt = `HALF_DIVIDE_BY_8_SEL;
        end else begin
            halfCnt = `HALF_DIVIDE_BY_4_SEL; // Divide by four, also when no bit set
        end
    end

    // Half-period enable pulse; held at zero while idle so frames align
    always_ff @(posedge mclk) begin
        if (rst || state_reg == SH_IDLE) begin
            divCnt_reg <= 8'h00;
        end else if (tick) begin
            divCnt_reg <= 8'h00;
        end else begin
            divCnt_reg <= divCnt_reg + 8'h01;
        end
    end
    assign tick = (state_reg != SH_IDLE) && (divCnt_reg == halfCnt - 8'h01);

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    // Master only: this engine always owns the clock
    assign lastEdge = (state_reg == SH_HIGH) && tick && (bitCnt_reg == 3'h7);
    assign popIf.ready = (state_reg == SH_IDLE) || lastEdge;
    assign rxDone = lastEdge;

    // Eight clocks per word, out and in together
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= SH_IDLE;
            sclk_reg <= 1'b0;
            bitCnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                SH_IDLE: begin
                    if (popIf.valid) begin
                        state_reg <= SH_LOW;
                        bitCnt_reg <= 3'h0;
                    end
                end
                SH_LOW: begin
                    if (tick) begin
                        sclk_reg <= 1'b1;
                        state_reg <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (tick) begin
                        sclk_reg <= 1'b0;
                        bitCnt_reg <= bitCnt_reg + 3'h1;
                        if (bitCnt_reg != 3'h7 || popIf.valid) begin
                            state_reg <= SH_LOW;
                        end else begin
                            state_reg <= SH_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= SH_IDLE;
                end
            endcase
        end
    end

    // Sample on rising edge; shift out on falling edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_reg <= 8'h00;
            inBit_reg <= 1'b0;
        end else if (popIf.ready && popIf.valid) begin
            shift_reg <= popIf.data;
        end else if (state_reg == SH_LOW && tick) begin
            inBit_reg <= serialInLine;
        end else if (state_reg == SH_HIGH && tick) begin
            shift_reg <= {shift_reg[6:0], inBit_reg};
        end
    end

    // Select low across back-to-back words, one slave only
    always_ff @(posedge mclk) begin
        if (rst) begin
            ssel_reg <= 1'b0;
        end else if (state_reg == SH_IDLE) begin
            ssel_reg <= popIf.valid;
        end else if (lastEdge && !popIf.valid) begin
            ssel_reg <= 1'b0;
        end
    end

    assign serialOutLine = shift_reg[7];
    assign serialClockOut = sclk_reg;
    assign slaveSelectOut_n = !ssel_reg;

    // ****************************************************************
    // Receive holding and status flags
    // ****************************************************************
    // Newest word overwrites; set wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            rxHold_reg <= 8'h00;
            rxFull_reg <= 1'b0;
            rxOverrun_reg <= 1'b0;
            txEnd_reg <= 1'b0;
        end else begin
            if (rxDone) begin
                rxHold_reg <= {shift_reg[6:0], inBit_reg};
            end
            if (rxDone) begin
                rxFull_reg <= 1'b1;
            end else if (sfrRd && sfrAddr == `RXDATA_ADDR) begin
                rxFull_reg <= 1'b0;
            end
            if (rxDone && rxFull_reg) begin
                rxOverrun_reg <= 1'b1;
            end else if (sfrWr && sfrAddr == `STATUS_ADDR
                         && sfrWrData[`BIT_RX_OVERRUN]) begin
                rxOverrun_reg <= 1'b0;
            end
            if (lastEdge && !popIf.valid) begin
                txEnd_reg <= 1'b1;
            end else if (sfrWr && sfrAddr == `STATUS_ADDR
                         && sfrWrData[`BIT_TX_END]) begin
                txEnd_reg <= 1'b0;
            end
        end
    end

    // Transmit empty is a level: nothing left waiting to be shifted
    assign txEmpty = !popIf.valid;
    assign status = {txEnd_reg, rxOverrun_reg, txEmpty, rxFull_reg};

    // Enabled status ORed to one request
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status & irqEn_reg[3:0]);
        end
    end
    assign irq = irq_reg;

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_reg <= 8'h00;
        end else if (sfrRd) begin
            if (sfrAddr == `CLKDIV_ADDR) begin
                rdData_reg <= clkDiv_reg;
            end else if (sfrAddr == `IRQEN_ADDR) begin
                rdData_reg <= irqEn_reg;
            end else if (sfrAddr == `RXDATA_ADDR) begin
                rdData_reg <= rxHold_reg;
            end else if (sfrAddr == `STATUS_ADDR) begin
                rdData_reg <= {3'h0, state_reg != SH_IDLE, status};
            end else begin
                rdData_reg <= 8'h00;
            end
        end
    end
    assign sfrRdData = rdData_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [7:0] hiCnt_reg;
    logic [5:0] edgeCnt_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            hiCnt_reg <= 8'h00;
            edgeCnt_reg <= 6'h00;
        end else begin
            hiCnt_reg <= sclk_reg ? hiCnt_reg + 8'h01 : 8'h00;
            if (!ssel_reg) begin
                edgeCnt_reg <= 6'h00;
            end else if (state_reg == SH_LOW && tick) begin
                edgeCnt_reg <= {1'b1, edgeCnt_reg[4:0] + 5'h01}; // Top bit sticks
            end
        end
    end

    a_reset_values: assert property (@(posedge mclk)
        rst |=> (clkDiv_reg == 8'h04 && irqEn_reg == 8'h00))
        else $error("divider or enable register reset value wrong");
    a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
        (irqEn_reg == 8'h00) ##1 (irqEn_reg == 8'h00) |-> !irq)
        else $error("interrupt raised with all enables clear");
    a_irq_raised: assert property (@(posedge mclk) disable iff (rst)
        (rxFull_reg && irqEn_reg[0]) |=> irq)
        else $error("enabled receive full did not raise interrupt");
    a_half_period: assert property (@(posedge mclk) disable iff (rst)
        ($fell(sclk_reg) && $stable(clkDiv_reg)) |-> (hiCnt_reg == halfCnt))
        else $error("serial clock high time does not match divider");
    a_select_frame: assert property (@(posedge mclk) disable iff (rst)
        serialClockOut |-> !slaveSelectOut_n)
        else $error("serial clock toggles without slave selected");
    a_eight_bits: assert property (@(posedge mclk) disable iff (rst)
        $rose(slaveSelectOut_n) |-> (edgeCnt_reg[2:0] == 3'h0
                                     && edgeCnt_reg[5]))
        else $error("frame did not carry whole 8-bit words");
    a_overrun_set: assert property (@(posedge mclk) disable iff (rst)
        (rxDone && rxFull_reg) |=> rxOverrun_reg [*2])
        else $error("overrun not flagged on second unread word");
    a_tx_end: assert property (@(posedge mclk) disable iff (rst)
        $rose(slaveSelectOut_n) |-> txEnd_reg)
        else $error("transfer end not flagged when select released");
    a_out_stable: assert property (@(posedge mclk) disable iff (rst)
        (sclk_reg && $past(sclk_reg)) |-> $stable(serialOutLine))
        else $error("transmit line changed while clock high");
    a_rx_full: assert property (@(posedge mclk) disable iff (rst)
        rxDone |=> (rxFull_reg && rxHold_reg == $past({shift_reg[6:0],
                                                        inBit_reg})))
        else $error("received word not captured");

    c_word_done: cover property (@(posedge mclk) disable iff (rst) rxDone);
    c_overrun: cover property (@(posedge mclk) disable iff (rst)
        $rose(rxOverrun_reg));
    c_back_to_back: cover property (@(posedge mclk) disable iff (rst)
        lastEdge && popIf.valid);
    c_fifo_full: cover property (@(posedge mclk) disable iff (rst) !txSpace);
endmodule // spi_master_controller

// >>> tb/spi_slave_model.sv
// Behavioural SPI slave, mode 0, answering the master controller
`timescale 1ns/10ps
module spi_slave_model (
    input wire logic serialClockOut, // Serial clock from master
    input wire logic slaveSelectOut_n, // Select, active low
    input wire logic serialOutLine, // Data from master
    input wire logic [7:0] replyByte, // Base of the answer words
    output logic serialInLine, // Data to master
    output logic [7:0] gotByte, // Last whole word received
    output int bitCnt // Bits received so far
);
    logic [7:0] outSh;
    logic [7:0] inSh;

    // ****************************************
    // Shift logic
    // ****************************************
    // Start clean so the first frame has a known answer
    initial begin
        serialInLine = 1'b0;
        gotByte = 8'h00;
        bitCnt = 0;
        inSh = 8'h00;
        outSh = 8'h00;
    end
    always @(negedge slaveSelectOut_n) begin
        outSh = replyByte + 8'(bitCnt / 8);
        serialInLine = outSh[7];
    end
    // Released line inverts, so a stale bit can never match
    always @(posedge slaveSelectOut_n) begin
        serialInLine = ~serialInLine;
    end
    always @(posedge serialClockOut) begin
        if (!slaveSelectOut_n) begin
            inSh = {inSh[6:0], serialOutLine};
            bitCnt++;
            if (bitCnt % 8 == 0) begin
                gotByte = inSh;
            end
        end
    end
    always @(negedge serialClockOut) begin
        if (!slaveSelectOut_n) begin
            if (bitCnt % 8 == 0) begin
                outSh = replyByte + 8'(bitCnt / 8);
            end else begin
                outSh = {outSh[6:0], ~outSh[7]};
            end
            serialInLine = outSh[7];
        end
    end
endmodule // spi_slave_model

// >>> tb/tb_spi_master_controller.sv
// Self-checking bench for the SPI master controller
`timescale 1ns/10ps
`include "spi_defs.svh"
module tb_spi_master_controller;
    logic mclk, rst, sfrWr, sfrRd, txSpace, irq;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, replyByte, gotByte;
    logic serialInLine, serialOutLine, serialClockOut, slaveSelectOut_n;
    int bitCnt, selRises, errorCnt, samplesChecked;

    spi_master_controller i_spi_master_controller (.mclk(mclk), .rst(rst),
        .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .txSpace(txSpace),
        .serialInLine(serialInLine), .serialOutLine(serialOutLine),
        .serialClockOut(serialClockOut),
        .slaveSelectOut_n(slaveSelectOut_n), .irq(irq));
    spi_slave_model i_spi_slave_model (.serialClockOut(serialClockOut),
        .slaveSelectOut_n(slaveSelectOut_n), .serialOutLine(serialOutLine),
        .replyByte(replyByte), .serialInLine(serialInLine),
        .gotByte(gotByte), .bitCnt(bitCnt));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Frames are counted by select release
    always @(posedge slaveSelectOut_n) begin
        selRises++;
    end

    task automatic tallyAndFinish();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmpByte(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timedOut(input string what);
        errorCnt++;
        $display("[FAIL] %s expected done seen timeout", what);
        tallyAndFinish();
    endtask

    // Strobe for one edge, then a quiet edge so writes never collide
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWr <= 1'b1;
        @(posedge mclk);
        sfrWr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(posedge mclk);
        sfrRd <= 1'b0;
        @(posedge mclk);
        d = sfrRdData;
    endtask

    task automatic waitClk(input logic lvl, input int bound, output int n);
        n = 0;
        while (serialClockOut !== lvl) begin
            @(posedge mclk);
            n++;
            if (n > bound) timedOut("serial clock");
        end
    endtask

    // Polls status until engine idle and nothing is queued
    task automatic waitIdle(input int bound);
        logic [7:0] s;
        int n;
        n = 0;
        s = 8'h00;
        while (s[`BIT_BUSY] !== 1'b0 || s[`BIT_TX_EMPTY] !== 1'b1) begin
            regRead(`STATUS_ADDR, s);
            n++;
            if (n > bound) timedOut("idle");
        end
    endtask

    task automatic checkIrq(input logic exp);
        @(posedge mclk);
        @(posedge mclk);
        cmpByte("irq", {7'h00, exp}, {7'h00, irq});
    endtask

    // One word at divider bit k, half period measured on the wire
    task automatic xfer(input int k, input logic [7:0] tx,
                        input logic [7:0] rep, input logic readBack);
        logic [7:0] d, expRx, idle;
        int h;
        expRx = rep + 8'(bitCnt / 8);
        replyByte <= rep;
        regWrite(`CLKDIV_ADDR, 8'(1 << k)); // one bit only
        regWrite(`TXDATA_ADDR, tx);
        waitClk(1'b1, 300, h);
        waitClk(1'b0, 300, h);
        cmpByte("half period", 8'(1 << (k - 1)), 8'(h));
        waitIdle(2000);
        cmpByte("word at slave", tx, gotByte);
        idle = {6'h00, serialClockOut, slaveSelectOut_n};
        cmpByte("idle clock and select", 8'h01, idle);
        if (readBack) begin
            regRead(`RXDATA_ADDR, d);
            cmpByte("received word", expRx, d);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic checkResetValues();
        logic [7:0] d;
        regRead(`CLKDIV_ADDR, d);
        cmpByte("divider reset", `CLKDIV_RST, d);
        regRead(`IRQEN_ADDR, d);
        cmpByte("enable reset", `IRQEN_RST, d);
        checkIrq(1'b0);
        regRead(8'hA0, d);
        cmpByte("unmapped read", 8'h00, d);
        regWrite(`IRQEN_ADDR, 8'hFF);
        regRead(`IRQEN_ADDR, d);
        cmpByte("enable reserved bits", 8'h0F, d);
        // One divider bit plus both unused bits
        regWrite(`CLKDIV_ADDR, 8'h83);
        regRead(`CLKDIV_ADDR, d);
        cmpByte("divider unused bits", 8'h80, d);
        regWrite(`IRQEN_ADDR, 8'h00);
    endtask

    task automatic checkDividers();
        for (int k = 2; k <= 7; k++) begin
            xfer(k, 8'hA5 ^ 8'(k), 8'h3C + 8'(k), 1'b1);
        end
    endtask

    task automatic checkIrqSources();
        logic [7:0] d;
        regWrite(`STATUS_ADDR, 8'h0C);
        regWrite(`IRQEN_ADDR, 8'h02);
        checkIrq(1'b1);
        regWrite(`IRQEN_ADDR, 8'h08);
        checkIrq(1'b0);
        xfer(2, 8'h5A, 8'hC3, 1'b1);
        checkIrq(1'b1);
        regWrite(`STATUS_ADDR, 8'h08);
        checkIrq(1'b0);
        regWrite(`IRQEN_ADDR, 8'h01);
        xfer(3, 8'h81, 8'h18, 1'b0);
        checkIrq(1'b1);
        regRead(`RXDATA_ADDR, d);
        checkIrq(1'b0);
    endtask

    // Two queued words share one select; second overruns the first
    task automatic checkBackToBack();
        logic [7:0] d, expRx;
        int rises, bits;
        regWrite(`STATUS_ADDR, 8'h0C);
        regWrite(`IRQEN_ADDR, 8'h04);
        checkIrq(1'b0);
        rises = selRises;
        bits = bitCnt;
        expRx = replyByte + 8'(bitCnt / 8 + 1);
        regWrite(`TXDATA_ADDR, 8'h11);
        regWrite(`TXDATA_ADDR, 8'hEE);
        waitIdle(2000);
        cmpByte("select releases", 8'h01, 8'(selRises - rises));
        cmpByte("bits shifted", 8'h10, 8'(bitCnt - bits));
        cmpByte("second word at slave", 8'hEE, gotByte);
        checkIrq(1'b1);
        regRead(`RXDATA_ADDR, d);
        cmpByte("newest word kept", expRx, d);
        regWrite(`STATUS_ADDR, 8'h04);
        checkIrq(1'b0);
    endtask

    // Slowest clock keeps the queue full while it is loaded
    task automatic checkFifoFill();
        int n, bits;
        regWrite(`IRQEN_ADDR, 8'h00);
        regWrite(`CLKDIV_ADDR, 8'h80);
        bits = bitCnt;
        n = 0;
        while (txSpace === 1'b1 && n < 30) begin
            regWrite(`TXDATA_ADDR, 8'(n));
            n++;
        end
        cmpByte("words before full", 8'h12, 8'(n));
        regWrite(`TXDATA_ADDR, 8'hFF);
        waitIdle(20000);
        cmpByte("words sent", 8'h12, 8'((bitCnt - bits) / 8));
        cmpByte("last word", 8'h11, gotByte);
        cmpByte("space after drain", 8'h01, {7'h00, txSpace});
    endtask

    initial begin
        rst = 1'b1;
        sfrAddr = 8'h00;
        sfrWr = 1'b0;
        sfrRd = 1'b0;
        sfrWrData = 8'h00;
        replyByte = 8'h00;
        errorCnt = 0;
        samplesChecked = 0;
        selRises = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        checkResetValues();
        checkDividers();
        checkIrqSources();
        checkBackToBack();
        checkFifoFill();
        tallyAndFinish();
    end
endmodule // tb_spi_master_controller
